// ==== rtl/drive_status_flag_encoder.sv ====
/*
 * drive status flag encoder: zero-speed flag, over-torque flag and
 * trip-cause code on the intelligent output terminals, with an
 * axi4-lite register slave. assumes measurements and trip state are
 * synchronous to clk and that the torque estimator lives elsewhere.
 */
// Functional notes
// - zero-speed flag high while speed below level
// - function 21 routes zero-speed flag out
// - zero-speed level programmable 0.00 to 100.0 Hz
// - open-loop and sensorless methods compare output frequency
// - sensor vector method compares measured motor speed
// - over-torque flag when torque exceeds quadrant limit
// - function 07 routes over-torque flag out
// - four quadrant limits, 0 to 150 percent
// - over-torque meaningful only under vector methods
// - tripped drive shows binary cause code
// - width select: none, 3-bit, 4-bit
// - code overrides terminals 11 upward, LSB first
// - base codes 0 to 6 for common causes
// - 3-bit mode maps other causes to 7
// - 4-bit code 7 braking resistor overload
// - 4-bit codes 8 memory/processor, 9 sensor
// - 4-bit codes 10 external group, 11 ground
// - 4-bit code 12 sequence program faults
// - 4-bit code 13 overtemperature
// - 4-bit code 14 input phase loss
// - 4-bit code 15 user trips, option errors
module drive_status_flag_encoder
	import flag_enc_pkg::*;
#(
	parameter int TERM_COUNT = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// drive side inputs
	input wire drive_meas_t meas,
	input wire trip_info_t trip,
	// terminal side outputs
	output logic [TERM_COUNT-1:0] term_out,
	output logic relay_out,
	output logic zero_speed_flag,
	output logic torque_over_flag
);

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// software-visible configuration
	logic [31:0] ctrl_q; // width select and control method
	logic [15:0] zs_level_q; // zero_speed_level, 0.01 Hz units
	logic [31:0] tq_limit_q; // four torque limits, one byte each
	logic [6*TERM_COUNT-1:0] term_func_q; // output_terminal_function_select
	logic [5:0] relay_func_q; // relay_function_select

	// axi handshake state
	logic aw_full_q, w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// flag and code state
	logic zs_q, tq_q;
	logic trip_seen_q; // trip was already active last cycle
	logic [3:0] code_q; // 4-bit cause code held for the trip

	// configuration fields
	wire [1:0] width_sel = ctrl_q[CTRL_WIDTH_LSB +: 2]; // trip_code_width_select
	wire [2:0] method = ctrl_q[CTRL_METHOD_LSB +: 3];
	wire [7:0] fwd_powering_torque_limit = tq_limit_q[7:0];
	wire [7:0] rev_regen_torque_limit = tq_limit_q[15:8];
	wire [7:0] rev_powering_torque_limit = tq_limit_q[23:16];
	wire [7:0] fwd_regen_torque_limit = tq_limit_q[31:24];

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// clamp a torque limit byte to its legal range
	function automatic logic [7:0] clamp_lim(input logic [7:0] v);
		return (v > TQ_LIMIT_MAX) ? TQ_LIMIT_MAX : v;
	endfunction

	// 4-bit cause code table
	function automatic logic [3:0] cause_code(input trip_cause_t c);
		case (c)
			CAUSE_NONE: return 4'h0;
			CAUSE_OVERCURRENT: return 4'h1;
			CAUSE_OVERLOAD, CAUSE_LOWSPD_OVERLOAD: return 4'h2;
			CAUSE_OVERVOLT: return 4'h3;
			CAUSE_UNDERVOLT: return 4'h4;
			CAUSE_POWER_FAIL: return 4'h5;
			CAUSE_SWITCH_ERR: return 4'h6;
			CAUSE_BRAKE_RES_OVL: return 4'h7;
			CAUSE_NVM_ERR, CAUSE_CPU_ERR, CAUSE_GATE_ARRAY_COMM,
			CAUSE_MAIN_CIRCUIT: return 4'h8;
			CAUSE_CURRENT_SENSOR: return 4'h9;
			CAUSE_EXT_TRIP, CAUSE_RESTART_LOCKOUT, CAUSE_THERMISTOR,
			CAUSE_BRAKING: return 4'hA;
			CAUSE_GROUND_FAULT: return 4'hB;
			CAUSE_SEQ_INSTR, CAUSE_SEQ_NEST, CAUSE_SEQ_EXEC: return 4'hC;
			CAUSE_OVERTEMP, CAUSE_FAN_OVERTEMP: return 4'hD;
			CAUSE_PHASE_LOSS: return 4'hE;
			default: return 4'hF;
		endcase
	endfunction

	// write channel decode
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
	wire w_full_d = (w_full_q | w_take) & ~do_wr;
	wire bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
	wire wr_ctrl = do_wr & (aw_addr_q == ADDR_CTRL);
	wire wr_zs = do_wr & (aw_addr_q == ADDR_ZS_LEVEL);
	wire wr_lim = do_wr & (aw_addr_q == ADDR_TQ_LIMIT);
	wire wr_term = do_wr & (aw_addr_q == ADDR_TERM_FUNC);
	wire wr_relay = do_wr & (aw_addr_q == ADDR_RELAY_FUNC);
	wire wr_hit = wr_ctrl | wr_zs | wr_lim | wr_term | wr_relay;

	// merged write values; the level and limits saturate at their ranges
	wire [31:0] ctrl_m = merge(ctrl_q, w_data_q, w_strb_q);
	wire [31:0] zs_m = merge({16'h0000, zs_level_q}, w_data_q, w_strb_q);
	wire [15:0] zs_new = (zs_m[15:0] > ZS_LEVEL_MAX) ? ZS_LEVEL_MAX : zs_m[15:0];
	wire [31:0] lim_m = merge(tq_limit_q, w_data_q, w_strb_q);
	wire [31:0] lim_new = {clamp_lim(lim_m[31:24]), clamp_lim(lim_m[23:16]),
		clamp_lim(lim_m[15:8]), clamp_lim(lim_m[7:0])};
	wire [31:0] term_m = merge({{(32-6*TERM_COUNT){1'b0}}, term_func_q}, w_data_q, w_strb_q);
	wire [31:0] relay_m = merge({26'h0, relay_func_q}, w_data_q, w_strb_q);

	// read channel decode
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire [31:0] status_w;
	logic [31:0] rd_word;
	logic rd_hit;

	// read mux over the register map
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_CTRL: rd_word = ctrl_q;
			ADDR_ZS_LEVEL: rd_word = {16'h0000, zs_level_q};
			ADDR_TQ_LIMIT: rd_word = tq_limit_q;
			ADDR_TERM_FUNC: rd_word = {{(32-6*TERM_COUNT){1'b0}}, term_func_q};
			ADDR_RELAY_FUNC: rd_word = {26'h0, relay_func_q};
			ADDR_STATUS: rd_word = status_w;
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// axi handshake registers; ready drops right after each take
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			s_axi_awready <= ~aw_full_d & ~bvalid_d;
			s_axi_wready <= ~w_full_d & ~bvalid_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
		end
	end

	// captured payloads and answers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (aw_take) aw_addr_q <= s_axi_awaddr;
			if (w_take) w_data_q <= s_axi_wdata;
			if (w_take) w_strb_q <= s_axi_wstrb;
			// unmapped or read-only addresses answer with an error
			if (do_wr) s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (ar_take) s_axi_rdata <= rd_word;
			if (ar_take) s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
			zs_level_q <= ZS_LEVEL_RST;
			tq_limit_q <= TQ_LIMIT_RST;
			term_func_q <= TERM_FUNC_RST[6*TERM_COUNT-1:0];
			relay_func_q <= RELAY_FUNC_RST;
		end else begin
			// only the width and method fields are kept
			if (wr_ctrl) ctrl_q <= ctrl_m & 32'h0000_0073;
			if (wr_zs) zs_level_q <= zs_new;
			if (wr_lim) tq_limit_q <= lim_new;
			if (wr_term) term_func_q <= term_m[6*TERM_COUNT-1:0];
			if (wr_relay) relay_func_q <= relay_m[5:0];
		end
	end

	// speed source: measured speed only with a speed sensor
	wire use_speed = (method == METH_SENSOR_VECTOR);
	wire [15:0] mon_speed = use_speed ? meas.motor_speed : meas.out_freq;
	wire zs_d = (mon_speed < zs_level_q);

	// quadrant select from direction and torque sign
	wire tq_neg = meas.torque_est[15];
	wire [16:0] tq_mag = tq_neg ? (17'h0 - {1'b1, meas.torque_est})
		: {1'b0, meas.torque_est};
	logic [7:0] quad_lim;
	always_comb begin
		case ({meas.dir_rev, tq_neg})
			2'b00: quad_lim = fwd_powering_torque_limit;
			2'b01: quad_lim = fwd_regen_torque_limit;
			2'b11: quad_lim = rev_powering_torque_limit;
			default: quad_lim = rev_regen_torque_limit;
		endcase
	end

	// flag is forced low outside the vector methods, where it means nothing
	wire vector_meth = (method == METH_SENSORLESS) | (method == METH_ZR_SENSORLESS)
		| (method == METH_SENSOR_VECTOR);
	wire tq_d = vector_meth & (tq_mag > {9'h000, quad_lim});

	// cause code is caught on the first trip cycle and held
	wire [3:0] code_new = cause_code(trip.cause);
	wire [3:0] code_d = ~trip.active ? 4'h0 : (trip_seen_q ? code_q : code_new);
	wire [3:0] code3 = (code_q > 4'h6) ? 4'h7 : code_q;

	// flag and code registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			zs_q <= 1'b0;
			tq_q <= 1'b0;
			trip_seen_q <= 1'b0;
			code_q <= 4'h0;
		end else begin
			zs_q <= zs_d;
			tq_q <= tq_d;
			trip_seen_q <= trip.active;
			code_q <= code_d;
		end
	end

	// per-terminal function routing with code override
	logic [TERM_COUNT-1:0] term_d;
	genvar gi;
	generate
		for (gi = 0; gi < TERM_COUNT; gi++) begin : g_term
			wire [5:0] fsel = term_func_q[6*gi +: 6];
			wire routed = ((fsel == FUNC_ZERO_SPEED) & zs_q)
				| ((fsel == FUNC_TORQUE_OVER) & tq_q);
			if (gi < 4) begin : g_code
				// overrides only exist on the low terminals, so they live here
				wire force3 = (width_sel == WIDTH_3BIT) & (gi < 3);
				wire force4 = (width_sel == WIDTH_4BIT);
				assign term_d[gi] = force4 ? code_q[gi] : (force3 ? code3[gi] : routed);
			end else begin : g_plain
				assign term_d[gi] = routed;
			end
		end
	endgenerate

	// relay is never overridden by the code
	wire relay_d = ((relay_func_q == FUNC_ZERO_SPEED) & zs_q)
		| ((relay_func_q == FUNC_TORQUE_OVER) & tq_q);

	// pin registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			term_out <= '0;
			relay_out <= 1'b0;
			zero_speed_flag <= 1'b0;
			torque_over_flag <= 1'b0;
		end else begin
			term_out <= term_d;
			relay_out <= relay_d;
			zero_speed_flag <= zs_q;
			torque_over_flag <= tq_q;
		end
	end

	// status word shows the live pin state and held code
	assign status_w = ({{(32-TERM_COUNT){1'b0}}, term_out} << STAT_TERM_LSB)
		| ({31'h0, relay_out} << STAT_RELAY_BIT)
		| ({31'h0, zs_q} << STAT_ZS_BIT)
		| ({31'h0, tq_q} << STAT_TQ_BIT)
		| ({28'h0, code_q} << STAT_CODE_LSB);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_zs_low_speed: assert property ((mon_speed < zs_level_q) |=> ##1 zero_speed_flag)
		else $error("zero speed flag missing");
	a_zs_high_speed: assert property ((mon_speed >= zs_level_q) |=> ##1 !zero_speed_flag)
		else $error("zero speed flag spurious");
	a_level_range: assert property (zs_level_q <= ZS_LEVEL_MAX)
		else $error("zero speed level out of range");
	a_limit_range: assert property (tq_limit_q[7:0] <= TQ_LIMIT_MAX
		&& tq_limit_q[15:8] <= TQ_LIMIT_MAX && tq_limit_q[23:16] <= TQ_LIMIT_MAX
		&& tq_limit_q[31:24] <= TQ_LIMIT_MAX)
		else $error("torque limit out of range");
	a_tq_nonvector: assert property (!vector_meth |=> ##1 !torque_over_flag)
		else $error("torque flag outside vector methods");
	a_code_hold: assert property (trip.active && $past(trip.active) && trip_seen_q
		|=> $stable(code_q))
		else $error("trip code changed during trip");
	// code register clears one edge after the trip drops; a new trip may follow at once
	a_code_clear: assert property (!trip.active |=> (code_q == 4'h0))
		else $error("trip code not cleared");
	a_code_pins4: assert property ((width_sel == WIDTH_4BIT) && $stable(width_sel)
		|=> (term_out[3:0] == $past(code_q)))
		else $error("4-bit code not on terminals");
	a_code_pins3: assert property ((width_sel == WIDTH_3BIT) && $stable(width_sel)
		|=> (term_out[2:0] == $past(code3[2:0])))
		else $error("3-bit code not on terminals");
	a_bresp_follow: assert property (do_wr |=> s_axi_bvalid)
		else $error("write answer missing");

	c_trip_coded: cover property (trip.active && !trip_seen_q ##2 term_out != '0);
	c_zs_flag: cover property (!zero_speed_flag ##1 zero_speed_flag);
	c_tq_flag: cover property (vector_meth && tq_d ##2 torque_over_flag);
	c_code3_other: cover property ((width_sel == WIDTH_3BIT) && trip.active ##2 term_out[2:0] == 3'h7);

endmodule

// ==== rtl/flag_enc_pkg.sv ====
/*
 * shared constants and carriers for the drive status flag encoder:
 * register map, field layout, reset values, function and cause codes.
 * assumes a 32-bit axi4-lite master and one drive clock.
 */
package flag_enc_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ZS_LEVEL = 8'h04;
	localparam logic [7:0] ADDR_TQ_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_TERM_FUNC = 8'h0C;
	localparam logic [7:0] ADDR_RELAY_FUNC = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ctrl fields
	localparam int CTRL_WIDTH_LSB = 0;
	localparam int CTRL_METHOD_LSB = 4;

	// status fields
	localparam int STAT_TERM_LSB = 0;
	localparam int STAT_RELAY_BIT = 5;
	localparam int STAT_ZS_BIT = 8;
	localparam int STAT_TQ_BIT = 9;
	localparam int STAT_CODE_LSB = 12;

	// limits of programmable values
	localparam logic [15:0] ZS_LEVEL_MAX = 16'h2710; // 100.00 Hz in 0.01 Hz
	localparam logic [7:0] TQ_LIMIT_MAX = 8'h96; // 150 percent

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] ZS_LEVEL_RST = 16'h0000;
	localparam logic [31:0] TQ_LIMIT_RST = 32'h6464_6464;
	localparam logic [29:0] TERM_FUNC_RST = 30'h0000_0000;
	localparam logic [5:0] RELAY_FUNC_RST = 6'h00;

	// trip-code width select
	localparam logic [1:0] WIDTH_NONE = 2'h0;
	localparam logic [1:0] WIDTH_3BIT = 2'h1;
	localparam logic [1:0] WIDTH_4BIT = 2'h2;

	// terminal function codes
	localparam logic [5:0] FUNC_TORQUE_OVER = 6'h07;
	localparam logic [5:0] FUNC_ZERO_SPEED = 6'h15;

	// control method codes
	localparam logic [2:0] METH_CONST_TORQUE = 3'h0;
	localparam logic [2:0] METH_REDUCED_TORQUE = 3'h1;
	localparam logic [2:0] METH_FREE_VF = 3'h2;
	localparam logic [2:0] METH_SENSORLESS = 3'h3;
	localparam logic [2:0] METH_ZR_SENSORLESS = 3'h4;
	localparam logic [2:0] METH_SENSOR_VECTOR = 3'h5;

	// trip cause codes presented by the protection logic
	typedef enum logic [4:0] {
		CAUSE_NONE, CAUSE_OVERCURRENT, CAUSE_OVERLOAD, CAUSE_LOWSPD_OVERLOAD,
		CAUSE_OVERVOLT, CAUSE_UNDERVOLT, CAUSE_POWER_FAIL, CAUSE_SWITCH_ERR,
		CAUSE_BRAKE_RES_OVL, CAUSE_NVM_ERR, CAUSE_CPU_ERR, CAUSE_GATE_ARRAY_COMM,
		CAUSE_MAIN_CIRCUIT, CAUSE_CURRENT_SENSOR, CAUSE_EXT_TRIP, CAUSE_RESTART_LOCKOUT,
		CAUSE_THERMISTOR, CAUSE_BRAKING, CAUSE_GROUND_FAULT, CAUSE_SEQ_INSTR,
		CAUSE_SEQ_NEST, CAUSE_SEQ_EXEC, CAUSE_OVERTEMP, CAUSE_FAN_OVERTEMP,
		CAUSE_PHASE_LOSS, CAUSE_USER_TRIP, CAUSE_OPTION_ERR
	} trip_cause_t;

	// drive measurements sampled each cycle
	typedef struct packed {
		logic [15:0] out_freq; // 0.01 Hz units
		logic [15:0] motor_speed; // 0.01 Hz units
		logic signed [15:0] torque_est; // percent, sign = torque direction
		logic dir_rev; // rotation direction is reverse
	} drive_meas_t;

	// trip state from the protection logic
	typedef struct packed {
		logic active;
		trip_cause_t cause;
	} trip_info_t;

endpackage

// ==== bench/term_sampler.sv ====
/*
 * external controller model: latches the intelligent output terminals
 * and the relay on every rising edge and counts edges without a terminal change.
 * assumes the encoder drives its terminal outputs from registers on clk.
 */
module term_sampler (
	// clock
	input wire logic clk,
	// pins watched
	input wire logic [4:0] term_out,
	input wire logic relay_out,
	// what the controller has latched
	output logic [4:0] seen_term_q,
	output logic seen_relay_q,
	output int steady_q
);
	timeunit 1ns;
	timeprecision 1ns;

	// a real controller only sees edge samples, so a code must stand still to be read
	always @(posedge clk) begin
		steady_q <= (term_out === seen_term_q) ? steady_q + 1 : 0;
		seen_term_q <= term_out;
		seen_relay_q <= relay_out;
	end
endmodule

// ==== bench/drive_status_flag_encoder_bench.sv ====
/*
 * self-checking bench for the drive status flag encoder: axi4-lite
 * master tasks, an integer model of flags and trip codes, a sampler.
 * assumes the package, the design and term_sampler are compiled first.
 */
module drive_status_flag_encoder_bench import flag_enc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// 4-bit code for each cause, in enum order
	localparam int CODE4[27] = '{0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 8, 8, 8, 9, 10, 10, 10, 10, 11,
		12, 12, 12, 13, 13, 14, 15, 15};
	// reset values at offsets 0x00..0x18, last one unmapped
	localparam logic [31:0] RV[7] = '{CTRL_RST, 32'(ZS_LEVEL_RST), TQ_LIMIT_RST,
		32'(TERM_FUNC_RST), 32'(RELAY_FUNC_RST), 32'h0, 32'h0};

	// clock, reset and bus master side
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, relay_out, zs_flag, tq_flag, seen_relay_q;
	logic [1:0] bresp, rresp;
	// drive side
	drive_meas_t meas = '0;
	trip_info_t trip = '0;
	logic [4:0] term_out, seen_term_q;
	int steady_q, fail_count, checks_done, cyc;
	logic [15:0] lfsr_q = 16'h3B7C; // seed 15228

	always #25 clk = ~clk;

	drive_status_flag_encoder DUT (.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas(meas), .trip(trip), .term_out(term_out), .relay_out(relay_out),
		.zero_speed_flag(zs_flag), .torque_over_flag(tq_flag));

	term_sampler partner (.clk(clk), .term_out(term_out), .relay_out(relay_out),
		.seen_term_q(seen_term_q), .seen_relay_q(seen_relay_q), .steady_q(steady_q));

	// lfsr step, result reduced below m
	function automatic int rnd(input int m);
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return int'(lfsr_q) % m;
	endfunction

	// code on the terminals for width w and cause c
	function automatic logic [3:0] exp_code(input int w, input int c);
		if (w == 2) return 4'(CODE4[c]);
		if (w == 1) return (CODE4[c] > 6) ? 4'h7 : 4'(CODE4[c]);
		return 4'h0;
	endfunction

	// terminals 11..15 carry zs, tq, zs, tq, zs unless the code overrides the low ones
	function automatic logic [4:0] exp_term(input int w, input logic [3:0] code,
		input logic zs, input logic tq);
		if (w == 2) return {zs, code};
		if (w == 1) return {zs, tq, code[2:0]};
		return {zs, tq, zs, tq, zs};
	endfunction

	task automatic chk_flag(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_term(input logic [4:0] got, input logic [4:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t terminals got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [31:0] d, input logic [1:0] r, input logic [31:0] ed,
		input logic [1:0] er);
		checks_done++;
		if (d !== ed || r !== er) begin
			fail_count++;
			$display("BAD %0t register got %h/%0d expected %h/%0d", $time, d, r, ed, er);
		end
	endtask

	// one write; address and data released as each is taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				done = 1'b1;
				bready <= 1'b0;
			end
		end
	endtask

	// one read; data taken at the edge that sees rvalid
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				done = 1'b1;
				rready <= 1'b0;
			end
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// hang guard, well above the fewer than two thousand cycles the tests take
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic dir, ezs, etq;
		int m, f, s, lvl, tqv, q;
		int lim[4];
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, read-only and unmapped places, clamping
		for (int i = 0; i < 7; i++) begin
			axi_rd(8'(4 * i), d, r);
			chk_reg(d, r, RV[i], (i == 6) ? 2'h2 : 2'h0);
		end
		axi_wr(ADDR_STATUS, 32'hF, r);
		chk_reg(32'h0, r, 32'h0, 2'h2);
		axi_wr(ADDR_ZS_LEVEL, 32'hFFFF, r);
		axi_rd(ADDR_ZS_LEVEL, d, r);
		chk_reg(d, r, 32'(ZS_LEVEL_MAX), 2'h0);
		axi_wr(ADDR_TQ_LIMIT, 32'hFFFF_FFFF, r);
		axi_rd(ADDR_TQ_LIMIT, d, r);
		chk_reg(d, r, {4{TQ_LIMIT_MAX}}, 2'h0);
		// byte enables: only the reverse regenerating limit changes
		wstrb <= 4'h2;
		axi_wr(ADDR_TQ_LIMIT, 32'h0000_2200, r);
		wstrb <= 4'hF;
		chk_reg(32'h0, r, 32'h0, 2'h0);
		axi_rd(ADDR_TQ_LIMIT, d, r);
		chk_reg(d, r, {TQ_LIMIT_MAX, TQ_LIMIT_MAX, 8'h22, TQ_LIMIT_MAX}, 2'h0);
		axi_wr(ADDR_TERM_FUNC, {2'h0, FUNC_ZERO_SPEED, FUNC_TORQUE_OVER, FUNC_ZERO_SPEED,
			FUNC_TORQUE_OVER, FUNC_ZERO_SPEED}, r);
		axi_wr(ADDR_RELAY_FUNC, {26'h0, FUNC_TORQUE_OVER}, r);
		$display("test registers done");
		// random speeds, levels, torques and limits over every method
		for (int i = 0; i < 40; i++) begin
			m = i % 8;
			lvl = rnd(10001);
			f = (i % 4 == 0) ? lvl : rnd(12000);
			s = (i % 4 == 1) ? lvl : rnd(12000);
			for (int k = 0; k < 4; k++) lim[k] = rnd(151);
			dir = 1'(rnd(2));
			tqv = rnd(401) - 200;
			q = dir ? ((tqv >= 0) ? 1 : 2) : ((tqv >= 0) ? 0 : 3);
			if (i % 3 == 0) tqv = (tqv < 0) ? -lim[q] : lim[q];
			axi_wr(ADDR_CTRL, 32'(m << 4), r);
			axi_wr(ADDR_ZS_LEVEL, 32'(lvl), r);
			axi_wr(ADDR_TQ_LIMIT, {8'(lim[3]), 8'(lim[2]), 8'(lim[1]), 8'(lim[0])}, r);
			meas <= '{out_freq: 16'(f), motor_speed: 16'(s), torque_est: 16'(tqv), dir_rev: dir};
			repeat (3) @(posedge clk);
			ezs = (((m == 5) ? s : f) < lvl);
			etq = (((tqv < 0) ? -tqv : tqv) > lim[q]);
			chk_flag(zs_flag, ezs);
			// torque output is forced low outside the vector methods and only checked under them
			if (m >= 3 && m <= 5) begin
				chk_flag(tq_flag, etq);
				chk_term(term_out, exp_term(0, 4'h0, ezs, etq));
				chk_flag(relay_out, etq);
			end
		end
		$display("test flags done");
		// every cause under each width, sensor vector method, zero speed held true
		axi_wr(ADDR_ZS_LEVEL, 32'h64, r);
		meas <= '0;
		for (int w = 0; w < 4; w++) begin
			axi_wr(ADDR_CTRL, 32'(w) | 32'h50, r);
			for (int c = 0; c < 27; c++) begin
				trip <= '{active: 1'b1, cause: trip_cause_t'(5'(c))};
				repeat (3) @(posedge clk);
				chk_term(term_out, exp_term(w, exp_code(w, c), 1'b1, 1'b0));
				trip.cause <= trip_cause_t'(5'((c + 1) % 27));
				repeat (4) @(posedge clk);
				chk_term(seen_term_q, exp_term(w, exp_code(w, c), 1'b1, 1'b0));
				chk_flag(steady_q >= 3, 1'b1);
				trip <= '0;
				repeat (3) @(posedge clk);
				chk_term(term_out, exp_term(w, 4'h0, 1'b1, 1'b0));
			end
		end
		$display("test trip codes done");
		tally_and_finish();
	end
endmodule
